//--- logic/ccs_consts.vh
// Constants for the card contact sequencer: offsets, fields, timing counts
`ifndef CCS_CONSTS_VH
`define CCS_CONSTS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define CCS_OFF_PWR_CTRL   8'h00
`define CCS_OFF_HW_STATUS  8'h04
`define CCS_OFF_IRQ_CLEAR  8'h08
`define CCS_OFF_IRQ_ENABLE 8'h0c
`define CCS_OFF_WAKE_CTRL  8'h10
`define CCS_OFF_SEQ_STATE  8'h14

// ---------------------------------------------------------------
// power_control_reg fields
// ---------------------------------------------------------------
`define CCS_PCR_START      0
`define CCS_PCR_RSTDRV     1
`define CCS_PCR_SLEEP      2

// ---------------------------------------------------------------
// hardware_status_reg fields
// ---------------------------------------------------------------
`define CCS_HSR_CARD_PRESENT_PIN_CHG   0
`define CCS_HSR_PROT       1
`define CCS_HSR_OTEMP      2
`define CCS_HSR_SUPPLY_LOW_LATCH       3
`define CCS_HSR_WIDTH      4

// ---------------------------------------------------------------
// Wake control fields
// ---------------------------------------------------------------
`define CCS_WAKE_RX        0
`define CCS_WAKE_INT1      1
`define CCS_WAKE_INT1_EN   2

// ---------------------------------------------------------------
// Timing, in 1/64 T steps (one oscillator pulse each; T is 64 of them); wake delay in clock cycles
// ---------------------------------------------------------------
`define CCS_OSC_DIV        7'd64
`define CCS_ACT_T1         10'd3
`define CCS_ACT_T2         10'd99
`define CCS_ACT_T3         10'd227
`define CCS_ACT_T4         10'd259
`define CCS_DEA_T11        10'd3
`define CCS_DEA_T12        10'd35
`define CCS_DEA_T13        10'd67
`define CCS_DEA_T14        10'd99
`define CCS_DEA_T15        10'd227
`define CCS_WAKE_DELAY     11'd1536

`endif

//--- logic/ccs_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module ccs_sync #(
	parameter W = 1
) (
	input  wire         i_clk,   // System clock
	input  wire         i_rst_b, // Synchronous reset, active low
	input  wire [W-1:0] i_async, // Pin levels
	output reg  [W-1:0] o_sync   // Filtered levels
);

	reg [W-1:0] stage1; // Read only by stage2
	reg [W-1:0] stage2;
	reg [W-1:0] stage3;

	// ---------------------------------------------------------------
	// Pipeline; a change counts once stage 2 and 3 agree
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1)
		begin : g_bit
			always @(posedge i_clk)
			begin
				if (!i_rst_b)
				begin
					stage1[g] <= 1'b0;
					stage2[g] <= 1'b0;
					stage3[g] <= 1'b0;
					o_sync[g] <= 1'b0;
				end
				else
				begin
					stage1[g] <= i_async[g];
					stage2[g] <= stage1[g];
					stage3[g] <= stage2[g];
					// Hold until the two later stages agree
					if (stage2[g] == stage3[g])
						o_sync[g] <= stage3[g];
				end
			end
		end
	endgenerate

endmodule // ccs_sync

`default_nettype wire

//--- logic/ccs_top.v
// Card contact sequencer with AXI4-Lite registers and wake logic
`timescale 1ns/1ps
`default_nettype none
`include "ccs_consts.vh"

// Notes on behaviour
// R1 - Insert, remove, overcurrent, reset levels wake device
// R2 - RX or int1 falling edge wakes when enabled
// R3 - Software sets wake enables as required
// R4 - Wait 1536 cycles before leaving power-down
// R5 - Inactive: contacts low, converter stopped
// R6 - Software configures UART before setting start
// R7 - Activation: converter, supply, IO, clock timed
// R8 - Card reset rises only by software bit
// R9 - Sequencer T is oscillator divided by 64
// R10 - Deactivation: reset, clock, IO, supply, stop
// R11 - Faults and removal force automatic deactivation
// R12 - Emergency: interrupt, status bit, clear start
// R13 - Dropout: deactivate, chip reset, flag supply
// R14 - Activation needs card present, supply good
// R15 - Offsets counted in 1/64 T ticks
module ccs_top (
	input  wire        i_clk,          // 20 MHz system clock
	input  wire        i_rst_b,        // Synchronous reset, active low
	input  wire        i_osc_tick,     // Internal oscillator pulse, same clock
	input  wire        i_card_present, // Card present pin, high when in
	input  wire        i_prot_fault,   // Supply or reset overcurrent
	input  wire        i_overtemp,     // Die overheating
	input  wire        i_supply_low,   // Supervisor active
	input  wire        i_chip_reset,   // Chip reset pin, active high
	input  wire        i_card_rst_in,  // Card reset contact level
	input  wire        i_rx,           // Serial receive line
	input  wire        i_ext_int_b,    // External interrupt, active low
	input  wire        i_powerdown,    // Controller entered power-down
	input  wire [31:0] i_awaddr,       // AXI write address
	input  wire        i_awvalid,
	output reg         o_awready,
	input  wire [31:0] i_wdata,
	input  wire [3:0]  i_wstrb,
	input  wire        i_wvalid,
	output reg         o_wready,
	output reg  [1:0]  o_bresp,
	output reg         o_bvalid,
	input  wire        i_bready,
	input  wire [31:0] i_araddr,
	input  wire        i_arvalid,
	output reg         o_arready,
	output reg  [31:0] o_rdata,
	output reg  [1:0]  o_rresp,
	output reg         o_rvalid,
	input  wire        i_rready,
	output reg         o_dcdc_en,      // DC/DC converter run
	output reg         o_vcc_en,       // Card supply ramp on
	output reg         o_io_en,        // I/O pulled up to supply
	output reg         o_clk_en,       // Card clock sent
	output reg         o_rst_en,       // Card reset contact enabled
	output reg         o_card_rst,     // Card reset contact high
	output reg         o_low_imp,      // Contacts clamped to card_ground
	output reg         o_wake,         // Leave power-down (level)
	output reg         o_chip_reset,   // Full chip reset pulse
	output reg         o_host_int_b    // host_interrupt_n, active low
);

	// ---------------------------------------------------------------
	// States, one-hot
	// ---------------------------------------------------------------
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_ACT  = 4'b0010;
	localparam [3:0] ST_ON   = 4'b0100;
	localparam [3:0] ST_DEA  = 4'b1000;

	// ---------------------------------------------------------------
	// Synchronised pins
	// ---------------------------------------------------------------
	wire [8:0] pins_s;   // Filtered pin levels
	ccs_sync #(.W(9)) u_sync (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_async ({i_powerdown, i_card_rst_in, i_ext_int_b, i_rx, i_chip_reset,
			i_supply_low, i_overtemp, i_prot_fault, i_card_present}),
		.o_sync  (pins_s)
	);
	wire card_present_pin_s  = pins_s[0];
	wire prot_s  = pins_s[1];
	wire otemp_s = pins_s[2];
	wire supply_low_latch_s  = pins_s[3];
	wire crst_s  = pins_s[4];
	wire rx_s    = pins_s[5];
	wire int_s   = pins_s[6];
	wire card_reset_drive_bit_s = pins_s[7];
	wire pd_s    = pins_s[8];

	reg        card_present_pin_d;   // Previous presence
	reg        rx_d;     // Previous receive level
	reg        int_d;    // Previous interrupt level
	reg        supply_low_latch_d;   // Previous supervisor level
	reg        start;    // power_control_reg start bit
	reg        rst_drv;  // card_reset_drive_bit
	reg        sleep_req; // Stop card clock while powered down
	reg  [2:0] wake_ctl; // rx_wake_enable, ext_int_wake_enable, int enabled
	reg  [3:0] status;   // hardware_status_reg sticky bits
	reg  [3:0] irq_en;   // Interrupt enable mask
	reg  [3:0] state;    // Sequencer state
	reg  [9:0] sub;      // Position in 1/64 T ticks
	reg  [5:0] div;      // Phase within T, in oscillator pulses
	reg        tick;     // One 1/64 T step
	reg [10:0] wake_cnt; // Wake delay counter
	reg        supply_low_latch_pend; // Dropout awaiting idle state for chip reset
	reg        aw_held;
	reg        w_held;
	reg  [7:0] aw_addr;
	reg [31:0] w_data;

	// ---------------------------------------------------------------
	// Divider: one step per oscillator pulse, div wraps once per T
	// ---------------------------------------------------------------
	always @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			div  <= 6'h00;
			tick <= 1'b0;
		end
		else
		begin
			// A coarser step could not place the 3/64 T offsets
			tick <= i_osc_tick;                     // see R15
			if (i_osc_tick)
			begin
				div <= div + 6'h01;                 // see R9
			end
		end
	end

	// Faults that end a session, and those that also interrupt
	wire removed   = card_present_pin_d & ~card_present_pin_s;
	wire emerg     = ~card_present_pin_s | prot_s | otemp_s;               // see R11
	wire any_fault = emerg | supply_low_latch_s | crst_s;                  // see R11
	wire act_ok    = start & card_present_pin_s & ~supply_low_latch_s & ~any_fault;    // see R14

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			state      <= ST_IDLE;
			sub        <= 10'h000;
			o_dcdc_en  <= 1'b0;
			o_vcc_en   <= 1'b0;
			o_io_en    <= 1'b0;
			o_clk_en   <= 1'b0;
			o_rst_en   <= 1'b0;
			o_card_rst <= 1'b0;
			o_low_imp  <= 1'b1;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					// Everything low and clamped while inactive
					o_dcdc_en <= 1'b0;                  // see R5
					o_low_imp <= 1'b1;                  // see R5
					sub       <= 10'h000;
					if (act_ok)
						state <= ST_ACT;
				end
				ST_ACT:
				begin
					if (!start || any_fault)
					begin
						state <= ST_DEA;
						sub   <= 10'h000;
					end
					else if (tick)
					begin
						sub <= sub + 10'h001;           // see R15
						if (sub == `CCS_ACT_T1 - 10'h001)
						begin
							o_dcdc_en <= 1'b1;          // see R7
							o_low_imp <= 1'b0;
						end
						if (sub == `CCS_ACT_T2 - 10'h001)
							o_vcc_en <= 1'b1;           // see R7
						if (sub == `CCS_ACT_T3 - 10'h001)
							o_io_en <= 1'b1;            // see R7
						if (sub == `CCS_ACT_T4 - 10'h001)
						begin
							o_clk_en <= 1'b1;           // see R7
							o_rst_en <= 1'b1;
							state    <= ST_ON;
						end
					end
				end
				ST_ON:
				begin
					// Reset contact follows software only
					o_card_rst <= rst_drv;              // see R8
					// Sleep stops the clock low while powered down
					o_clk_en   <= ~(sleep_req & pd_s);
					if (!start || any_fault)
					begin
						state <= ST_DEA;
						sub   <= 10'h000;
					end
				end
				ST_DEA:
				begin
					if (tick)
					begin
						sub <= sub + 10'h001;           // see R15
						if (sub == `CCS_DEA_T11 - 10'h001)
						begin
							o_card_rst <= 1'b0;         // see R10
							o_rst_en   <= 1'b0;
						end
						if (sub == `CCS_DEA_T12 - 10'h001)
							o_clk_en <= 1'b0;           // see R10
						if (sub == `CCS_DEA_T13 - 10'h001)
							o_io_en <= 1'b0;            // see R10
						if (sub == `CCS_DEA_T14 - 10'h001)
							o_vcc_en <= 1'b0;           // see R10
						if (sub == `CCS_DEA_T15 - 10'h001)
						begin
							o_dcdc_en <= 1'b0;          // see R10
							o_low_imp <= 1'b1;
							state     <= ST_IDLE;
						end
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Session ends with a finished deactivation
	wire dea_done = (state == ST_DEA) & tick & (sub == `CCS_DEA_T15 - 10'h001);

	// ---------------------------------------------------------------
	// Dropout: chip reset after deactivation, flag when supply good
	// ---------------------------------------------------------------
	always @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			supply_low_latch_pend    <= 1'b0;
			o_chip_reset <= 1'b0;
			supply_low_latch_d       <= 1'b0;
		end
		else
		begin
			supply_low_latch_d       <= supply_low_latch_s;
			o_chip_reset <= 1'b0;
			if (supply_low_latch_pend && state == ST_IDLE && !o_chip_reset)
			begin
				o_chip_reset <= 1'b1;                   // see R13
				supply_low_latch_pend    <= 1'b0;
			end
			// One reset per dropout, even with the card already down
			if (supply_low_latch_s && !supply_low_latch_d)
				supply_low_latch_pend <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Wake from power-down or sleep
	// ---------------------------------------------------------------
	wire wake_ev = (card_present_pin_d ^ card_present_pin_s) | prot_s | card_reset_drive_bit_s | crst_s      // see R1
		| (wake_ctl[`CCS_WAKE_RX] & rx_d & ~rx_s)                        // see R2
		| (wake_ctl[`CCS_WAKE_INT1] & wake_ctl[`CCS_WAKE_INT1_EN]
			& int_d & ~int_s);                                           // see R2

	always @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			// Low like the synchroniser, so no false fall after reset
			card_present_pin_d   <= 1'b0;
			rx_d     <= 1'b0;
			int_d    <= 1'b0;
			wake_cnt <= 11'h000;
			o_wake   <= 1'b0;
		end
		else
		begin
			card_present_pin_d <= card_present_pin_s;
			rx_d   <= rx_s;
			int_d  <= int_s;
			if (!pd_s)
			begin
				wake_cnt <= 11'h000;
				o_wake   <= 1'b0;
			end
			else if (wake_cnt != 11'h000)
			begin
				// Serial data during this wait may be lost
				wake_cnt <= wake_cnt + 11'h001;
				if (wake_cnt == `CCS_WAKE_DELAY)
				begin
					o_wake   <= 1'b1;                   // see R4
					wake_cnt <= 11'h000;
				end
			end
			else if (wake_ev && !o_wake)
				wake_cnt <= 11'h001;
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite write channel
	// ---------------------------------------------------------------
	reg w_strb_lo;   // Low lane strobe of held write
	wire do_wr = aw_held & w_held & ~o_bvalid;
	wire [3:0] clr_bits = (do_wr && aw_addr == `CCS_OFF_IRQ_CLEAR && w_strb_lo)
		? w_data[3:0] : 4'h0;

	// Events that set status bits
	wire [3:0] ev_set;
	assign ev_set[`CCS_HSR_CARD_PRESENT_PIN_CHG] = card_present_pin_d ^ card_present_pin_s;
	assign ev_set[`CCS_HSR_PROT]     = prot_s & (state != ST_IDLE);
	assign ev_set[`CCS_HSR_OTEMP]    = otemp_s & (state != ST_IDLE);
	assign ev_set[`CCS_HSR_SUPPLY_LOW_LATCH]     = supply_low_latch_d & ~supply_low_latch_s;

	always @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			o_awready <= 1'b0;
			o_wready  <= 1'b0;
			o_bvalid  <= 1'b0;
			o_bresp   <= 2'h0;
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr   <= 8'h00;
			w_data    <= 32'h0;
			w_strb_lo <= 1'b0;
			start     <= 1'b0;
			rst_drv   <= 1'b0;
			sleep_req <= 1'b0;
			wake_ctl  <= 3'h0;
			irq_en    <= 4'h0;
			status    <= 4'h0;
		end
		else
		begin
			o_awready <= ~aw_held & ~(i_awvalid & o_awready);
			o_wready  <= ~w_held & ~(i_wvalid & o_wready);
			if (i_awvalid && o_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= i_awaddr[7:0];
			end
			if (i_wvalid && o_wready)
			begin
				w_held    <= 1'b1;
				w_data    <= i_wdata;
				w_strb_lo <= i_wstrb[0];
			end
			if (do_wr)
			begin
				aw_held  <= 1'b0;
				w_held   <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp  <= 2'h0;
				case (aw_addr)
					`CCS_OFF_PWR_CTRL:
						if (w_strb_lo)
						begin
							// Host configures UART before this
							start     <= w_data[`CCS_PCR_START];  // see R6
							rst_drv   <= w_data[`CCS_PCR_RSTDRV]; // see R8
							sleep_req <= w_data[`CCS_PCR_SLEEP];
						end
					`CCS_OFF_WAKE_CTRL:
						if (w_strb_lo)
							wake_ctl <= w_data[2:0];               // see R3
					`CCS_OFF_IRQ_ENABLE:
						if (w_strb_lo)
							irq_en <= w_data[3:0];
					`CCS_OFF_IRQ_CLEAR:
						o_bresp <= 2'h0;
					`CCS_OFF_HW_STATUS,
					`CCS_OFF_SEQ_STATE:
						o_bresp <= 2'h0;
					default:
						o_bresp <= 2'h2;
				endcase
			end
			else if (o_bvalid && i_bready)
				o_bvalid <= 1'b0;
			// Emergency clears start; later write loses to it
			if (emerg && state != ST_IDLE)
				start <= 1'b0;                                 // see R12
			if (dea_done)
				rst_drv <= 1'b0;
			// Set wins over clear
			status <= (status & ~clr_bits) | ev_set;           // see R12
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read channel
	// ---------------------------------------------------------------
	always @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0;
			o_rresp   <= 2'h0;
		end
		else
		begin
			o_arready <= ~o_rvalid & ~(i_arvalid & o_arready);
			if (i_arvalid && o_arready)
			begin
				o_rvalid <= 1'b1;
				o_rresp  <= 2'h0;
				case (i_araddr[7:0])
					`CCS_OFF_PWR_CTRL:
						o_rdata <= {29'h0, sleep_req, rst_drv, start};
					`CCS_OFF_HW_STATUS:
						o_rdata <= {28'h0, status};
					`CCS_OFF_IRQ_CLEAR:
						o_rdata <= 32'h0;
					`CCS_OFF_IRQ_ENABLE:
						o_rdata <= {28'h0, irq_en};
					`CCS_OFF_WAKE_CTRL:
						o_rdata <= {29'h0, wake_ctl};
					`CCS_OFF_SEQ_STATE:
						o_rdata <= {10'h0, div, card_present_pin_s, o_wake, state, sub};
					default:
					begin
						o_rdata <= 32'h0;
						o_rresp <= 2'h2;
					end
				endcase
			end
			else if (o_rvalid && i_rready)
				o_rvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt: low while enabled status set or supervisor active
	// ---------------------------------------------------------------
	always @(posedge i_clk)
	begin
		if (!i_rst_b)
			o_host_int_b <= 1'b0;
		else
			o_host_int_b <= ~(|(status & irq_en) | supply_low_latch_s);    // see R12
	end

endmodule // ccs_top

`default_nettype wire

//--- tb/ccs_chk.sv
// Checker for contact ordering, wake delay and bus holding
`timescale 1ns/1ps
`default_nettype none
module ccs_chk (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_powerdown,
	input wire logic i_bready,
	input wire logic o_bvalid,
	input wire logic o_dcdc_en,
	input wire logic o_vcc_en,
	input wire logic o_io_en,
	input wire logic o_clk_en,
	input wire logic o_rst_en,
	input wire logic o_card_rst,
	input wire logic o_low_imp,
	input wire logic o_wake,
	input wire logic o_chip_reset
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// ----------------------------------------
	// Helper: cycles spent in power-down
	// ----------------------------------------
	logic [11:0] pd_cnt; // Saturates, so a long stay cannot wrap
	always @(posedge i_clk)
		if (!i_rst_b || !i_powerdown)
			pd_cnt <= 12'h000;
		else if (pd_cnt != 12'hfff)
			pd_cnt <= pd_cnt + 12'h001;
	// I/O stays off well after supply starts
	sequence s_io_off;
		!o_io_en [*8];
	endsequence
	// Clock keeps running after reset falls
	sequence s_clk_on;
		o_clk_en [*8];
	endsequence
	a_inact_low: assert property (!o_dcdc_en |-> !o_vcc_en && !o_io_en && !o_clk_en)
		else $error("contact live with converter off");
	a_lowimp_off: assert property (o_low_imp |-> !o_vcc_en && !o_io_en && !o_card_rst)
		else $error("contact live while clamped");
	a_vcc_after: assert property ($rose(o_vcc_en) |-> $past(o_dcdc_en) ##0 s_io_off)
		else $error("supply order wrong");
	a_clk_order: assert property (o_clk_en |-> o_io_en && o_vcc_en)
		else $error("clock before I/O");
	a_rst_gate: assert property (o_card_rst |-> o_rst_en && o_vcc_en && o_io_en)
		else $error("card reset while unpowered");
	a_deact_clk: assert property ($fell(o_rst_en) |-> s_clk_on)
		else $error("clock stopped with reset");
	a_wake_dly: assert property ($rose(o_wake) |-> pd_cnt >= 12'd1536)
		else $error("wake too early");
	a_chip_pulse: assert property (o_chip_reset |=> !o_chip_reset)
		else $error("chip reset not a pulse");
	a_bus_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
		else $error("write answer dropped");
endmodule // ccs_chk
bind ccs_top ccs_chk ccs_chk_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_powerdown(i_powerdown),
	.i_bready(i_bready), .o_bvalid(o_bvalid), .o_dcdc_en(o_dcdc_en), .o_vcc_en(o_vcc_en),
	.o_io_en(o_io_en), .o_clk_en(o_clk_en), .o_rst_en(o_rst_en), .o_card_rst(o_card_rst),
	.o_low_imp(o_low_imp), .o_wake(o_wake), .o_chip_reset(o_chip_reset));
`default_nettype wire

//--- tb/ccs_card.sv
// Behavioural card in the slot: presence, reset contact level, overcurrent
`timescale 1ns/1ps
`default_nettype none
module ccs_card (
	input  wire logic i_inserted, // Card sits in the slot
	input  wire logic i_short,    // Card draws too much current
	input  wire logic i_vcc,      // Supply reaching the card
	input  wire logic i_rst_en,   // Reset contact driven
	input  wire logic i_card_rst, // Reset contact high
	output wire logic o_present,  // Presence switch
	output wire logic o_rst_lvl,  // Level seen on reset contact
	output wire logic o_fault     // Overcurrent sensed
);
	assign o_present = i_inserted;
	// Unpowered card pulls the contact low
	assign o_rst_lvl = i_vcc & i_rst_en & i_card_rst;
	// A short only draws current when powered
	assign o_fault = i_short & i_vcc;
endmodule // ccs_card
`default_nettype wire

//--- tb/ccs_top_tb.sv
// Self-checking bench for the card contact sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ccs_consts.vh"
module ccs_top_tb;
	logic clk = 0, rst_b = 0, ins = 0, shrt = 0, sl = 0, rx = 1, ext = 1, pd = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, d;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [1:0] r;
	wire card_present_pin, rlvl, flt, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	wire [1:0] o_bresp, o_rresp;
	wire [31:0] o_rdata;
	wire dc, vc, io, ck, re, crst, limp, wake, chrst, int_b;
	int fail_count = 0, total_checks = 0, cyc = 0, n, t0, w;
	int tr[5], tf[5];
	logic [4:0] pv = 0;
	logic osc = 0;
	wire [4:0] cv = {re, ck, io, vc, dc};
	always #25 clk = ~clk;
	// Oscillator pulse on every other clock
	always @(posedge clk) osc <= ~osc;
	ccs_card ccs_card_i (.i_inserted(ins), .i_short(shrt), .i_vcc(vc), .i_rst_en(re),
		.i_card_rst(crst), .o_present(card_present_pin), .o_rst_lvl(rlvl), .o_fault(flt));
	ccs_top ccs_top_i (.i_clk(clk), .i_rst_b(rst_b), .i_osc_tick(osc), .i_card_present(card_present_pin),
		.i_prot_fault(flt), .i_overtemp(1'b0), .i_supply_low(sl), .i_chip_reset(1'b0),
		.i_card_rst_in(rlvl), .i_rx(rx), .i_ext_int_b(ext), .i_powerdown(pd),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(o_awready), .i_wdata(wdata),
		.i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
		.o_bvalid(o_bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
		.i_rready(rready), .o_dcdc_en(dc), .o_vcc_en(vc), .o_io_en(io), .o_clk_en(ck),
		.o_rst_en(re), .o_card_rst(crst), .o_low_imp(limp), .o_wake(wake),
		.o_chip_reset(chrst), .o_host_int_b(int_b));
	// ----------------------------------------
	// Edge log of the contact controls
	// ----------------------------------------
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		for (int k = 0; k < 5; k++)
		begin
			if (cv[k] && !pv[k]) tr[k] = cyc;
			if (!cv[k] && pv[k]) tf[k] = cyc;
		end
		pv <= cv;
	end
	// ----------------------------------------
	// Compare helpers and verdict
	// ----------------------------------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask
	// Interval check; phase of the step divider allows a small slack
	task near(input string nm, input int e, input int g, input int tol);
		total_checks++;
		if (g > e + tol || g + tol < e)
		begin
			$display("BAD %s expected %0d seen %0d", nm, e, g);
			fail_count++;
		end
	endtask
	task finish_test;
		if (fail_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// AXI4-Lite write, address and data offered together
	task wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (awvalid && o_awready) awvalid <= 1'b0;
			if (wvalid && o_wready) wvalid <= 1'b0;
			if (o_bvalid) break;
		end
		r = o_bresp;
		bready <= 1'b0;
		if (n == 50) fail_count++;
	endtask
	task rd(input logic [31:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (arvalid && o_arready) arvalid <= 1'b0;
			if (o_rvalid) break;
		end
		d = o_rdata;
		r = o_rresp;
		rready <= 1'b0;
		if (n == 50) fail_count++;
	endtask
	task wait_cyc(input int c);
		repeat (c) @(posedge clk);
	endtask
	// Activate and wait for the clock to reach the card
	task activate;
		wr(`CCS_OFF_PWR_CTRL, 32'h1);
		t0 = cyc;
		for (n = 0; n < 20000 && ck !== 1'b1; n++) @(posedge clk);
		wait_cyc(2);
	endtask
	initial
	begin
		#(20000 * 50);
		fail_count++;
		finish_test;
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(9));
		wait_cyc(2);
		rst_b <= 1'b1;
		wait_cyc(3);
		chk("dcdc idle", 0, {dc, vc, io, ck, crst});
		chk("clamp idle", 1, limp);
		wr(32'h18, 32'h1);
		chk("unmapped wr", 2, r);
		rd(32'h18);
		chk("unmapped rd", 2, r);
		w = $urandom % 8;
		wr(`CCS_OFF_WAKE_CTRL, w);
		rd(`CCS_OFF_WAKE_CTRL);
		chk("wake reg", w, d[2:0]);
		wr(`CCS_OFF_PWR_CTRL, 32'h1);
		wait_cyc(400);
		chk("no card start", 0, dc);
		wr(`CCS_OFF_PWR_CTRL, 32'h0);
		// Masked insertion, then enable, then clear
		wr(`CCS_OFF_IRQ_ENABLE, 32'h0);
		ins <= 1'b1;
		wait_cyc(20);
		chk("masked irq", 1, int_b);
		rd(`CCS_OFF_HW_STATUS);
		chk("card_present_pin chg", 1, d[`CCS_HSR_CARD_PRESENT_PIN_CHG]);
		wr(`CCS_OFF_IRQ_ENABLE, 32'h3);
		wait_cyc(3);
		chk("irq on", 0, int_b);
		wr(`CCS_OFF_IRQ_CLEAR, 32'h1);
		wait_cyc(3);
		chk("irq clr", 1, int_b);
		activate();
		near("t1", `CCS_ACT_T1 * 2, tr[0] - t0, 4);
		near("vcc", 96 * 2, tr[1] - tr[0], 2);
		near("io", 224 * 2, tr[2] - tr[0], 2);
		near("clk", 256 * 2, tr[3] - tr[0], 2);
		chk("rst held", 0, crst);
		wr(`CCS_OFF_PWR_CTRL, 32'h5);
		pd <= 1'b1;
		wait_cyc(10);
		chk("sleep clk", 0, ck);
		pd <= 1'b0;
		wait_cyc(10);
		chk("sleep exit clk", 1, ck);
		wr(`CCS_OFF_PWR_CTRL, 32'h3);
		wait_cyc(5);
		chk("rst up", 1, crst);
		wr(`CCS_OFF_PWR_CTRL, 32'h0);
		t0 = cyc;
		for (n = 0; n < 16000 && dc !== 1'b0; n++) @(posedge clk);
		wait_cyc(2);
		near("t11", `CCS_DEA_T11 * 2, tf[4] - t0, 4);
		near("clk off", 32 * 2, tf[3] - tf[4], 2);
		near("io off", 64 * 2, tf[2] - tf[4], 2);
		near("vcc off", 96 * 2, tf[1] - tf[4], 2);
		near("dcdc off", 224 * 2, tf[0] - tf[4], 2);
		chk("clamp", 1, limp);
		activate();
		shrt <= 1'b1;
		for (n = 0; n < 16000 && dc !== 1'b0; n++) @(posedge clk);
		shrt <= 1'b0;
		chk("emerg off", 0, {dc, vc, io, ck});
		chk("emerg irq", 0, int_b);
		rd(`CCS_OFF_HW_STATUS);
		chk("prot bit", 1, d[`CCS_HSR_PROT]);
		rd(`CCS_OFF_PWR_CTRL);
		chk("start clr", 0, d[`CCS_PCR_START]);
		wr(`CCS_OFF_IRQ_CLEAR, 32'hf);
		// Wake by receive line, external interrupt, card removal
		for (int s = 0; s < 3; s++)
		begin
			wr(`CCS_OFF_WAKE_CTRL, s == 0 ? 32'h3 : s == 1 ? 32'h6 : 32'h0);
			pd <= 1'b1;
			wait_cyc(10);
			chk("no early wake", 0, wake);
			if (s == 0) rx <= 1'b0;
			if (s == 1) ext <= 1'b0;
			if (s == 2) ins <= 1'b0;
			t0 = cyc;
			for (n = 0; n < 2000 && wake !== 1'b1; n++) @(posedge clk);
			near("wake dly", `CCS_WAKE_DELAY + 5, cyc - t0, 6);
			pd <= 1'b0;
			rx <= 1'b1;
			ext <= 1'b1;
			wait_cyc(10);
		end
		sl <= 1'b1;
		for (n = 0; n < 100 && chrst !== 1'b1; n++) @(posedge clk);
		chk("chip rst", 1, chrst);
		chk("supply_low_latch irq", 0, int_b);
		sl <= 1'b0;
		wait_cyc(20);
		rd(`CCS_OFF_HW_STATUS);
		chk("supply_low_latch", 1, d[`CCS_HSR_SUPPLY_LOW_LATCH]);
		finish_test;
	end
endmodule // ccs_top_tb
`default_nettype wire
